/* shared/fmb_pkg.sv */
// package for the mailbox and bus-matching core: constants and port carriers
package fmb_pkg;

    // data widths and lane positions
    localparam int FMB_LONG_W        = 36;
    localparam int FMB_WORD_W        = 18;
    localparam int FMB_BYTE_W        = 9;
    localparam int FMB_MAIL_LO       = 18;  // mail for the wide port sits on bits 35..18
    // memory depth and reset preset of the full offsets
    localparam int FMB_DEPTH_DEFAULT = 2048;
    localparam int FMB_OFFSET_PRESET = 8;
    localparam int FMB_DEPTH_MIN     = 16;
    // pieces left after a long word is split, per size
    localparam logic [1:0] FMB_BYTE_PIECES = 2'h3;
    localparam logic [1:0] FMB_WORD_PIECES = 2'h1;
    // order of the pins that pass through the synchroniser
    localparam int FMB_PIN_MR1   = 0;
    localparam int FMB_PIN_MR2   = 1;
    localparam int FMB_PIN_BE    = 2;
    localparam int FMB_PIN_TRANSMIT_SIZE_SELECT = 3;
    localparam int FMB_PIN_RECEIVE_SIZE_SELECT = 4;
    localparam int FMB_PIN_N     = 5;

    // 36-bit bidirectional port, input side
    typedef struct packed {
        logic                  wide_port_select_n;
        logic                  wide_port_direction;   // high = write into the device
        logic                  wide_port_enable;
        logic                  mail_select_wide_port;
        logic [FMB_LONG_W-1:0] data;
    } fmb_wide_in_t;

    // 18-bit transmit port controls
    typedef struct packed {
        logic transmit_port_select_n;
        logic transmit_read_enable;
        logic mail_select_transmit_port;
    } fmb_tx_in_t;

    // 18-bit receive port; long words arrive already assembled
    typedef struct packed {
        logic                  receive_write_enable;
        logic                  mail_select_receive_port;
        logic [FMB_WORD_W-1:0] data;
        logic                  long_write;
        logic [FMB_LONG_W-1:0] long_data;
    } fmb_rx_in_t;

    // reset, strap and offset programming pins
    typedef struct packed {
        logic master_reset_first_n;
        logic master_reset_second_n;
        logic endian_select;
        logic transmit_size_select;
        logic receive_size_select;
        logic offset_load_first;
        logic offset_load_second;
        logic offset_serial_enable;
        logic offset_serial_data;
    } fmb_cfg_in_t;

    // status flags
    typedef struct packed {
        logic almost_full_port_a;
        logic almost_full_port_c;
        logic mail_full_first;
        logic mail_full_second;
        logic wide_full_input_ready;
        logic receive_full_input_ready;
    } fmb_flags_t;

endpackage

/* core/fmb_core.sv */
// two-fifo core with almost-full flags, mail registers and transmit bus matching
`timescale 1ns/1ps
// Overview of operation
// R1 - almost-full flags run on the writing port clock
// R2 - flag low when count reaches depth minus offset
// R3 - flag high at depth minus offset-plus-one or less
// R4 - output-register word no longer counts as stored
// R5 - flag rises second edge after releasing read
// R6 - offsets preset, parallel loaded, or serially shifted
// R7 - mail select steers transfer to mail or fifo
// R8 - wide-port write with mail select fills mail one
// R9 - mail one keeps 18 or 9 low lines
// R10 - receive write with mail select fills mail two
// R11 - mail two keeps 18 or 9 low lines
// R12 - write drives mail flag low, blocks rewrites
// R13 - outputs show fifo register or mail by select
// R14 - transmit mail read sets first flag high
// R15 - wide mail read sets second flag high
// R16 - reads keep mail; endian never reorders mail
// R17 - receive mail select held high through reset
// R18 - size selects independent and static in operation
// R19 - sizes and endian applied at reset end
// R20 - endian sampled on master reset rising edge
// R21 - memories hold only 36-bit long words
// R22 - narrow reads split long word via auxiliary register
module fmb_core
    import fmb_pkg::*;
#(
    parameter int DEPTH         = FMB_DEPTH_DEFAULT,
    parameter int OFFSET_PRESET = FMB_OFFSET_PRESET
) (
    input  wire logic                  i_core_clk,
    input  wire logic                  i_rst_b,
    input  wire fmb_wide_in_t          i_wide,
    input  wire fmb_tx_in_t            i_tx,
    input  wire fmb_rx_in_t            i_rx,
    input  wire fmb_cfg_in_t           i_cfg,
    output logic [FMB_LONG_W-1:0]      o_wide_data,
    output logic                       o_wide_oe_n,
    output logic [FMB_WORD_W-1:0]      o_tx_data,
    output fmb_flags_t                 o_flags
);

    localparam int          AW       = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_C  = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] PRESET_C = AW'(OFFSET_PRESET);

    // refuse depths the pointer arithmetic cannot serve
    if (DEPTH < FMB_DEPTH_MIN || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("fmb_core: DEPTH must be a power of two of at least 16");
    end

    // the preset must fit the offset register and leave a usable threshold
    if (OFFSET_PRESET < 0 || OFFSET_PRESET >= DEPTH) begin : g_bad_preset
        $error("fmb_core: OFFSET_PRESET must lie below DEPTH");
    end

    typedef struct packed {
        logic [FMB_PIN_N-1:0]  sync_a;     // first synchroniser stage
        logic [FMB_PIN_N-1:0]  sync_b;     // second synchroniser stage
        logic [1:0]            mr_prev;
        logic                  big_endian;
        logic                  tx_byte;
        logic                  rx_byte;
        logic [AW:0]           wp1;
        logic [AW:0]           rp1;
        logic [AW:0]           wp2;
        logic [AW:0]           rp2;
        logic [FMB_LONG_W-1:0] aux;
        logic [1:0]            left;
        logic [FMB_WORD_W-1:0] tx_piece;
        logic [FMB_LONG_W-1:0] out2;
        logic [AW-1:0]         off_first;
        logic [AW-1:0]         off_second;
        logic [FMB_WORD_W-1:0] mail_register_first;
        logic [FMB_WORD_W-1:0] mail_register_second;
        logic                  rel_a;
        logic                  rel_c;
        logic [FMB_LONG_W-1:0] wide_data;
        logic                  wide_oe_n;
        logic [FMB_WORD_W-1:0] tx_data;
        fmb_flags_t            flags;
    } fmb_state_t;

    fmb_state_t            st_q;
    fmb_state_t            st_d;
    logic [FMB_LONG_W-1:0] mem_first [DEPTH];
    logic [FMB_LONG_W-1:0] mem_second [DEPTH];
    logic                  we_first;
    logic                  we_second;

    // reorder a long word into transmit order, first piece in the top bits
    function automatic logic [FMB_LONG_W-1:0] fmb_order(input logic [FMB_LONG_W-1:0] w,
                                                        input logic byte_mode,
                                                        input logic big);
        logic [FMB_LONG_W-1:0] r;
        r = w;
        if (!big && byte_mode) begin
            r = {w[8:0], w[17:9], w[26:18], w[35:27]};
        end else if (!big) begin
            r = {w[17:0], w[35:18]};
        end
        return r;
    endfunction

    // next-state logic for the whole core
    always_comb begin
        logic          mr1_n;
        logic          mr2_n;
        logic          a_wr;
        logic          a_rd;
        logic          b_rd;
        logic          c_mail;
        logic [AW:0]   cnt1_q;
        logic [AW:0]   cnt2_q;
        logic [AW:0]   cnt1_d;
        logic [AW:0]   cnt2_d;
        logic [AW:0]   thr1;
        logic [AW:0]   thr2;
        logic [FMB_LONG_W-1:0] seq;
        st_d      = st_q;
        we_first  = 1'b0;
        we_second = 1'b0;
        mr1_n     = st_q.sync_b[FMB_PIN_MR1];
        mr2_n     = st_q.sync_b[FMB_PIN_MR2];
        a_wr      = ~i_wide.wide_port_select_n & i_wide.wide_port_enable
                    & i_wide.wide_port_direction;
        a_rd      = ~i_wide.wide_port_select_n & i_wide.wide_port_enable
                    & ~i_wide.wide_port_direction;
        b_rd      = ~i_tx.transmit_port_select_n & i_tx.transmit_read_enable;
        c_mail    = i_rx.receive_write_enable & i_rx.mail_select_receive_port;
        cnt1_q    = st_q.wp1 - st_q.rp1;
        cnt2_q    = st_q.wp2 - st_q.rp2;
        seq       = '0;
        cnt1_d    = '0;
        cnt2_d    = '0;
        thr1      = '0;
        thr2      = '0;

        // pins cross into the core clock through two flip-flops
        // logic reads only the second stage; the first may still be settling
        st_d.sync_a  = {i_cfg.receive_size_select, i_cfg.transmit_size_select,
                        i_cfg.endian_select, i_cfg.master_reset_second_n,
                        i_cfg.master_reset_first_n};
        st_d.sync_b  = st_q.sync_a;
        st_d.mr_prev = {mr2_n, mr1_n};

        // latch endian and sizes when either master reset is released
        // straps that move later are ignored, so sizes stay fixed for the run
        if ((mr1_n & ~st_q.mr_prev[0]) | (mr2_n & ~st_q.mr_prev[1])) begin
            st_d.big_endian = st_q.sync_b[FMB_PIN_BE];     // R20
            st_d.tx_byte    = st_q.sync_b[FMB_PIN_TRANSMIT_SIZE_SELECT];  // R19 R18
            st_d.rx_byte    = st_q.sync_b[FMB_PIN_RECEIVE_SIZE_SELECT];  // R19 R18
        end

        // offset programming: parallel from the wide port, or serial chain
        if (a_wr && i_cfg.offset_load_first) begin
            st_d.off_first = i_wide.data[AW-1:0];  // R6
        end
        if (a_wr && i_cfg.offset_load_second) begin
            st_d.off_second = i_wide.data[AW-1:0];  // R6
        end
        if (i_cfg.offset_serial_enable) begin
            {st_d.off_first, st_d.off_second} =
                {st_q.off_first[AW-2:0], st_q.off_second, i_cfg.offset_serial_data};  // R6
        end

        // wide-port write: fifo one or mail one
        if (a_wr && !i_cfg.offset_load_first && !i_cfg.offset_load_second) begin
            if (!i_wide.mail_select_wide_port) begin
                if (st_q.flags.wide_full_input_ready) begin  // R7
                    we_first  = 1'b1;  // R21
                    st_d.wp1  = st_q.wp1 + 1'b1;
                end
            end
        end

        // transmit read: mail one released, or next piece of a long word
        // a mail read never touches the split state, so a half-sent word survives it
        if (b_rd && i_tx.mail_select_transmit_port) begin
            st_d.flags.mail_full_first = 1'b1;  // R14 R16
        end else if (b_rd && st_q.left != 2'h0) begin
            st_d.tx_piece = st_q.tx_byte ? {{FMB_BYTE_W{1'b0}}, st_q.aux[35:27]}
                                         : st_q.aux[35:18];  // R22
            st_d.aux      = st_q.tx_byte ? st_q.aux << FMB_BYTE_W : st_q.aux << FMB_WORD_W;
            st_d.left     = st_q.left - 2'h1;
        end else if (b_rd && cnt1_q != '0) begin
            seq           = fmb_order(mem_first[st_q.rp1[AW-1:0]], st_q.tx_byte,
                                      st_q.big_endian);
            st_d.rp1      = st_q.rp1 + 1'b1;  // R4
            st_d.tx_piece = st_q.tx_byte ? {{FMB_BYTE_W{1'b0}}, seq[35:27]}
                                         : seq[35:18];  // R22
            st_d.aux      = st_q.tx_byte ? seq << FMB_BYTE_W : seq << FMB_WORD_W;
            st_d.left     = st_q.tx_byte ? FMB_BYTE_PIECES : FMB_WORD_PIECES;
        end

        // mail one write comes after the read so a fresh write wins
        if (a_wr && i_wide.mail_select_wide_port && st_q.flags.mail_full_first) begin  // R8 R12
            st_d.mail_register_first = st_q.tx_byte ? {{FMB_BYTE_W{1'b0}}, i_wide.data[8:0]}
                                      : i_wide.data[17:0];  // R9
            st_d.flags.mail_full_first = 1'b0;  // R12
        end

        // receive side: assembled long words into fifo two
        if (i_rx.long_write && !i_rx.mail_select_receive_port
            && st_q.flags.receive_full_input_ready) begin  // R7
            we_second = 1'b1;  // R21
            st_d.wp2  = st_q.wp2 + 1'b1;
        end

        // wide-port read: mail two released, or fifo two into its output register
        if (a_rd && i_wide.mail_select_wide_port) begin
            st_d.flags.mail_full_second = 1'b1;  // R15 R16
        end else if (a_rd && cnt2_q != '0) begin
            st_d.out2 = mem_second[st_q.rp2[AW-1:0]];
            st_d.rp2  = st_q.rp2 + 1'b1;  // R4
        end

        // mail two write, gated while the flag shows unread mail
        if (c_mail && st_q.flags.mail_full_second) begin  // R10 R12
            st_d.mail_register_second = st_q.rx_byte ? {{FMB_BYTE_W{1'b0}}, i_rx.data[8:0]}
                                      : i_rx.data;  // R11
            st_d.flags.mail_full_second = 1'b0;  // R12
        end

        // master resets clear their fifo, preset their offset and set their mail flag high
        if (!mr1_n) begin
            st_d.wp1 = '0;
            st_d.rp1 = '0;
            st_d.aux = '0;
            st_d.left = 2'h0;
            st_d.tx_piece = '0;
            st_d.off_first = PRESET_C;  // R6
            st_d.flags.mail_full_first = 1'b1;
        end
        if (!mr2_n) begin
            st_d.wp2 = '0;
            st_d.rp2 = '0;
            st_d.out2 = '0;
            st_d.off_second = PRESET_C;  // R6
            st_d.flags.mail_full_second = 1'b1;  // R17
        end

        // almost-full: falls at once, rises two edges after the releasing read
        // rel_a and rel_c hold last cycle's below-threshold state, so a read
        // reaches the flag only on the second write-clock edge after it
        cnt1_d = st_d.wp1 - st_d.rp1;
        cnt2_d = st_d.wp2 - st_d.rp2;
        thr1   = DEPTH_C - {1'b0, st_d.off_first};  // R6
        thr2   = DEPTH_C - {1'b0, st_d.off_second};  // R6
        st_d.rel_a = cnt1_q < (DEPTH_C - {1'b0, st_q.off_first});  // R3
        st_d.rel_c = cnt2_q < (DEPTH_C - {1'b0, st_q.off_second});  // R3
        st_d.flags.almost_full_port_a = (cnt1_d < thr1) & st_q.rel_a;  // R1 R2 R5
        st_d.flags.almost_full_port_c = (cnt2_d < thr2) & st_q.rel_c;  // R1 R2 R5
        st_d.flags.wide_full_input_ready    = mr1_n & (cnt1_d != DEPTH_C);
        st_d.flags.receive_full_input_ready = mr2_n & (cnt2_d != DEPTH_C);

        // registered port outputs chosen by each port's mail select
        st_d.wide_oe_n = ~a_rd;
        st_d.wide_data = i_wide.mail_select_wide_port
                         ? {st_d.mail_register_second, {FMB_MAIL_LO{1'b0}}} : st_d.out2;  // R13 R16
        st_d.tx_data   = i_tx.mail_select_transmit_port ? st_d.mail_register_first : st_d.tx_piece;  // R13

        // core reset: fifos empty, mail flags idle, offsets at the preset
        if (!i_rst_b) begin
            st_d = '0;
            st_d.wide_oe_n = 1'b1;
            st_d.off_first = PRESET_C;
            st_d.off_second = PRESET_C;
            st_d.flags.mail_full_first = 1'b1;
            st_d.flags.mail_full_second = 1'b1;
            st_d.flags.almost_full_port_a = 1'b1;
            st_d.flags.almost_full_port_c = 1'b1;
            st_d.rel_a = 1'b1;
            st_d.rel_c = 1'b1;
            we_first = 1'b0;
            we_second = 1'b0;
        end
    end

    // state register
    always_ff @(posedge i_core_clk) begin
        st_q <= st_d;
    end

    // long-word memories, written only with whole 36-bit words
    // a word written on an edge is readable from the next cycle on
    always_ff @(posedge i_core_clk) begin
        if (we_first) begin
            mem_first[st_q.wp1[AW-1:0]] <= i_wide.data;  // R21
        end
        if (we_second) begin
            mem_second[st_q.wp2[AW-1:0]] <= i_rx.long_data;  // R21
        end
    end

    assign o_wide_data = st_q.wide_data;
    assign o_wide_oe_n = st_q.wide_oe_n;
    assign o_tx_data   = st_q.tx_data;
    assign o_flags     = st_q.flags;

endmodule

/* verification/fmb_core_props.sv */
// concurrent checks on the ports of the mailbox and bus-matching core
`timescale 1ns/1ps
module fmb_core_props
    import fmb_pkg::*;
#(
    parameter int DEPTH         = FMB_DEPTH_DEFAULT,
    parameter int OFFSET_PRESET = FMB_OFFSET_PRESET
) (
    input wire logic                  i_core_clk,
    input wire logic                  i_rst_b,
    input wire fmb_wide_in_t          i_wide,
    input wire fmb_tx_in_t            i_tx,
    input wire fmb_rx_in_t            i_rx,
    input wire fmb_cfg_in_t           i_cfg,
    input wire logic [FMB_LONG_W-1:0] o_wide_data,
    input wire logic                  o_wide_oe_n,
    input wire logic [FMB_WORD_W-1:0] o_tx_data,
    input wire fmb_flags_t            o_flags
);
    logic wsel;
    logic wmw;
    logic wmr;
    logic wfw;
    logic tmr;
    logic rmw;
    // decoded transfers on each port
    assign wsel = !i_wide.wide_port_select_n && i_wide.wide_port_enable;
    assign wmw  = wsel && i_wide.wide_port_direction && i_wide.mail_select_wide_port;
    assign wmr  = wsel && !i_wide.wide_port_direction && i_wide.mail_select_wide_port;
    assign wfw  = wsel && i_wide.wide_port_direction && !i_wide.mail_select_wide_port
                  && !i_cfg.offset_load_first && !i_cfg.offset_load_second;
    assign tmr  = !i_tx.transmit_port_select_n && i_tx.transmit_read_enable
                  && i_tx.mail_select_transmit_port;
    assign rmw  = i_rx.receive_write_enable && i_rx.mail_select_receive_port;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);

    // mail flags follow writes and reads; master reset pins reach the core two edges late
    a_mail_one_write: assert property (wmw && o_flags.mail_full_first
        && o_flags.wide_full_input_ready && $past(i_cfg.master_reset_first_n, 2)
        |=> !o_flags.mail_full_first) else $error("mail one flag");
    a_mail_one_read: assert property (tmr && !wmw |=> o_flags.mail_full_first)
        else $error("mail one read flag");
    a_mail_one_held: assert property (!o_flags.mail_full_first && !tmr
        && o_flags.wide_full_input_ready && $past(i_cfg.master_reset_first_n, 2)
        |=> !o_flags.mail_full_first) else $error("mail one held");
    a_mail_two_write: assert property (rmw && o_flags.mail_full_second
        && o_flags.receive_full_input_ready && $past(i_cfg.master_reset_second_n, 2)
        |=> !o_flags.mail_full_second) else $error("mail two");
    a_mail_two_read: assert property (wmr && !rmw |=> o_flags.mail_full_second)
        else $error("mail two read flag");
    // wide outputs after a read
    a_wide_out_enable: assert property (wsel && !i_wide.wide_port_direction |=> !o_wide_oe_n)
        else $error("wide outputs not driven");
    a_mail_two_lanes: assert property (wmr |=> o_wide_data[FMB_MAIL_LO-1:0] == '0)
        else $error("wide low lanes not clear");
    // almost-full may only fall after a fifo write
    a_full_a_fall: assert property ($fell(o_flags.almost_full_port_a) |-> $past(wfw))
        else $error("almost full a fell without write");
    a_full_c_fall: assert property ($fell(o_flags.almost_full_port_c)
        |-> $past(i_rx.long_write && !i_rx.mail_select_receive_port)) else $error("almost full c");

    c_mail_write: cover property (wmw);
    c_mail_read: cover property (tmr);
    c_full_rise: cover property ($rose(o_flags.almost_full_port_a));
endmodule

/* verification/fmb_host_model.sv */
// far-side controller model: strap pins and master reset pulses
`timescale 1ns/1ps
module fmb_host_model
    import fmb_pkg::*;
(
    input  wire logic  i_clk,
    output fmb_cfg_in_t o_cfg
);
    initial o_cfg = '0;
    // both master resets pulse together; straps are set before release and left static
    task automatic master_reset(input logic be, input logic sb, input logic sc);
        @(posedge i_clk);
        o_cfg <= '{1'b0, 1'b0, be, sb, sc, 1'b0, 1'b0, 1'b0, 1'b0};
        repeat (4) @(posedge i_clk);
        o_cfg.master_reset_first_n  <= 1'b1;
        o_cfg.master_reset_second_n <= 1'b1;
    endtask
    // serial offset chain sized for a depth of 16: msb first, first offset then second
    task automatic offset_shift(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) begin
            @(posedge i_clk);
            o_cfg.offset_serial_enable <= 1'b1;
            o_cfg.offset_serial_data   <= v[i];
        end
        @(posedge i_clk);
        o_cfg.offset_serial_enable <= 1'b0;
    endtask
    // parallel load strobe for the first offset, paired with one wide-port write
    task automatic offset_load(input logic first);
        @(posedge i_clk);
        o_cfg.offset_load_first <= first;
    endtask
endmodule

/* verification/fmb_core_tb.sv */
// self-checking bench for the mailbox and bus-matching core
`timescale 1ns/1ps
module fmb_core_tb;
    import fmb_pkg::*;
    localparam logic [35:0] D1 = 36'h9_8765_4321;
    localparam logic [35:0] L1 = 36'h1_2345_6789;
    localparam logic [17:0] M2 = 18'h2_b5c3;
    logic         i_core_clk;
    logic         i_rst_b;
    fmb_wide_in_t w;
    fmb_tx_in_t   t;
    fmb_rx_in_t   r;
    fmb_cfg_in_t  cfg;
    logic [35:0]  wd;
    logic         woe_n;
    logic [17:0]  td;
    fmb_flags_t   f;
    int           fails;
    int           checks_done;

    fmb_core #(.DEPTH(16), .OFFSET_PRESET(8)) u_dut (
        .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_wide(w), .i_tx(t), .i_rx(r),
        .i_cfg(cfg), .o_wide_data(wd), .o_wide_oe_n(woe_n), .o_tx_data(td), .o_flags(f));
    fmb_host_model u_host (.i_clk(i_core_clk), .o_cfg(cfg));

    initial i_core_clk = 1'b0;
    always #20 i_core_clk = ~i_core_clk;

    // one counted compare
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t: saw %h expected %h", $time, got, exp);
        end
    endtask
    // one wide-port cycle, then settle to the next falling edge
    task automatic wa(input logic wr, input logic mb, input logic [35:0] d);
        @(posedge i_core_clk);
        w <= '{1'b0, wr, 1'b1, mb, d};
        @(posedge i_core_clk);
        w <= '{1'b1, 1'b0, 1'b0, 1'b0, 36'h0};
        @(negedge i_core_clk);
    endtask
    // one transmit read, mail or fifo
    task automatic tr(input logic mb);
        @(posedge i_core_clk);
        t <= '{1'b0, 1'b1, mb};
        @(posedge i_core_clk);
        t <= '{1'b1, 1'b0, 1'b0};
        @(negedge i_core_clk);
    endtask
    // one receive transfer: mail word or assembled long word; idle keeps mail select high
    task automatic rx(input logic mail, input logic [35:0] d);
        @(posedge i_core_clk);
        r <= '{mail, mail, d[17:0], !mail, d};
        @(posedge i_core_clk);
        r <= '{1'b0, 1'b1, 18'h0, 1'b0, 36'h0};
        @(negedge i_core_clk);
    endtask
    // counts, verdict and end of run
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // main sequence: word big endian, then byte little endian
    initial begin
        fails = 0;
        checks_done = 0;
        i_rst_b = 1'b0;
        w = '{1'b1, 1'b0, 1'b0, 1'b0, 36'h0};
        t = '{1'b1, 1'b0, 1'b0};
        r = '{1'b0, 1'b1, 18'h0, 1'b0, 36'h0};
        repeat (4) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        u_host.master_reset(1'b1, 1'b0, 1'b0);
        repeat (10) @(negedge i_core_clk);
        chk(f.receive_full_input_ready, 1);
        chk(f.wide_full_input_ready, 1);
        wa(1, 1, D1);
        chk(f.mail_full_first, 0);
        wa(1, 1, L1);
        tr(1);
        chk(f.mail_full_first, 1);
        chk(td, D1[17:0]);
        tr(1);
        chk(td, D1[17:0]);
        rx(1, {18'h0, M2});
        chk(f.mail_full_second, 0);
        wa(0, 1, 36'h0);
        chk(wd, {M2, 18'h0});
        chk(f.mail_full_second, 1);
        chk(woe_n, 0);
        $display("mail test done");
        wa(1, 0, L1);
        repeat (4) @(negedge i_core_clk);
        tr(0);
        chk(td, L1[35:18]);
        tr(0);
        chk(td, L1[17:0]);
        for (int i = 0; i < 8; i++) begin
            wa(1, 0, 36'(i));
            chk(f.almost_full_port_a, i < 7);
        end
        repeat (4) @(negedge i_core_clk);
        tr(0);
        chk(f.almost_full_port_a, 0);
        @(negedge i_core_clk);
        chk(f.almost_full_port_a, 0);
        @(negedge i_core_clk);
        chk(f.almost_full_port_a, 1);
        repeat (15) tr(0);
        $display("fifo one test done");
        for (int i = 0; i < 8; i++) begin
            rx(0, L1 + 36'(i));
            chk(f.almost_full_port_c, i < 7);
        end
        repeat (4) @(negedge i_core_clk);
        wa(0, 0, 36'h0);
        chk(wd, L1);
        chk(f.almost_full_port_c, 0);
        repeat (2) @(negedge i_core_clk);
        chk(f.almost_full_port_c, 1);
        $display("fifo two test done");
        u_host.master_reset(1'b0, 1'b1, 1'b1);
        repeat (10) @(negedge i_core_clk);
        wa(1, 1, D1);
        tr(1);
        chk(td, {9'h0, D1[8:0]});
        rx(1, {18'h0, M2});
        wa(0, 1, 36'h0);
        chk(wd, {9'h0, M2[8:0], 18'h0});
        wa(1, 0, L1);
        repeat (4) @(negedge i_core_clk);
        for (int k = 0; k < 4; k++) begin
            tr(0);
            chk(td, {9'h0, L1[9*k +: 9]});
        end
        $display("byte test done");
        // offsets: serial chain sets first 8 and second 12, then first loaded to 4
        u_host.offset_shift(8'h8c);
        u_host.offset_load(1'b1);
        wa(1, 0, 36'h4);
        u_host.offset_load(1'b0);
        for (int i = 0; i < 4; i++) begin
            rx(0, L1);
            chk(f.almost_full_port_c, i < 3);
        end
        for (int i = 0; i < 12; i++) begin
            wa(1, 0, 36'(i));
            chk(f.almost_full_port_a, i < 11);
        end
        $display("offset test done");
        test_done();
    end

    // watchdog against a hang
    initial begin
        repeat (5000) @(posedge i_core_clk);
        fails++;
        test_done();
    end
endmodule

bind fmb_core fmb_core_props #(.DEPTH(DEPTH), .OFFSET_PRESET(OFFSET_PRESET)) u_props (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_wide(i_wide), .i_tx(i_tx), .i_rx(i_rx),
    .i_cfg(i_cfg), .o_wide_data(o_wide_data), .o_wide_oe_n(o_wide_oe_n),
    .o_tx_data(o_tx_data), .o_flags(o_flags));
